/* File: bench/abm_acc_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Processor access pipeline: presents one access per call
module abm_acc_model #(
	parameter int ADDR_W = 32
) (
	input wire logic hclk,
	output logic acc_valid,
	output abm_pkg::abm_kind_e acc_kind,
	output logic [ADDR_W-1:0] acc_addr,
	output logic [2:0] acc_len_m1
);
	// Idle lines at time zero
	initial begin
		acc_valid = 1'b0;
		acc_kind = abm_pkg::ACC_FETCH;
		acc_addr = '0;
		acc_len_m1 = 3'h0;
	end

	// One access cycle; released address and length lines show inverted values, the kind line keeps its last one
	task automatic present(input abm_pkg::abm_kind_e kind, input logic [ADDR_W-1:0] addr, input logic [2:0] len_m1);
		@(posedge hclk);
		acc_valid <= 1'b1;
		acc_kind <= kind;
		acc_addr <= addr;
		acc_len_m1 <= len_m1;
		@(posedge hclk);
		acc_valid <= 1'b0;
		acc_addr <= ~addr;
		acc_len_m1 <= ~len_m1;
	endtask : present
endmodule : abm_acc_model

/* File: bench/abm_top_tb_top.sv */
`timescale 1ns/10ps
module abm_top_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout, hresp, irq, debug_exception, acc_valid, task_switch = 1'b0;
	logic [31:0] hrdata, acc_addr, rd;
	logic [3:0] bp_hit;
	logic [2:0] acc_len_m1;
	abm_pkg::abm_kind_e acc_kind;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	// Table of accesses against three breakpoints: address, size less one, expected hits
	logic [31:0] t_addr [6] = '{32'h0000_EFFB, 32'h0000_EFFE, 32'h0000_EFFE, 32'h0000_F000, 32'h0000_F001, 32'h0000_F005};
	logic [2:0] t_len [6] = '{3'h7, 3'h1, 3'h3, 3'h0, 3'h1, 3'h3};
	logic [3:0] t_exp [6] = '{4'h5, 4'h0, 4'h5, 4'h5, 4'h4, 4'h6};

	// ==========================================================
	// Clock, device and far side
	always #4 hclk = ~hclk;

	abm_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr), .acc_len_m1(acc_len_m1),
		.task_switch(task_switch), .debug_exception(debug_exception), .bp_hit(bp_hit), .irq(irq));

	abm_acc_model i_model (.hclk(hclk), .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr),
		.acc_len_m1(acc_len_m1));

	// ==========================================================
	// Bus tasks, compare and verdict
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000, rd);
		chk(what, exp, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("hreadyout", 32'h1, {31'h0, hreadyout});
	endtask : rdchk

	// Present one access and compare the hit vector and exception one cycle later
	task automatic acc(input abm_pkg::abm_kind_e k, input logic [31:0] a, input logic [2:0] l, input logic [3:0] exp);
		i_model.present(k, a, l);
		#1;
		chk("bp_hit", {28'h000_0000, exp}, {28'h000_0000, bp_hit});
		chk("debug_exception", {31'h0, |exp}, {31'h0, debug_exception});
	endtask : acc

	function automatic logic type_hit(input logic [1:0] t, input abm_pkg::abm_kind_e k, input logic de);
		case (t)
			abm_pkg::TYPE_EXEC: return k == abm_pkg::ACC_FETCH;
			abm_pkg::TYPE_WR: return k == abm_pkg::ACC_DATA_WR;
			abm_pkg::TYPE_RW: return k inside {abm_pkg::ACC_DATA_RD, abm_pkg::ACC_DATA_WR};
			default: return de && (k inside {abm_pkg::ACC_IO_RD, abm_pkg::ACC_IO_WR});
		endcase
	endfunction : type_hit

	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict

	// Cuts a hang short
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk("ctrl", abm_pkg::OFS_CTRL, abm_pkg::CTRL_RST);
		rdchk("cfg", abm_pkg::OFS_CFG, 32'h0000_0000);
		rdchk("status", abm_pkg::OFS_STATUS, 32'h0000_0000);
		wr(8'h40, 32'hFFFF_FFFF);
		rdchk("unmapped", 8'h40, 32'h0000_0000);
		acc(abm_pkg::ACC_DATA_RD, 32'h0000_0000, 3'h0, 4'h0);
		$display("test reset done");
		// Aligned breakpoints: 1 byte at F000, 4 at F004, 8 at F000 given as F005, 1 disarmed
		wr(abm_pkg::OFS_BP_BASE, 32'h0000_F000);
		wr(abm_pkg::OFS_BP_BASE + 8'h04, 32'h0000_F004);
		wr(abm_pkg::OFS_BP_BASE + 8'h08, 32'h0000_F005);
		wr(abm_pkg::OFS_BP_BASE + 8'h0C, 32'h0000_F000);
		rdchk("bp1", abm_pkg::OFS_BP_BASE + 8'h04, 32'h0000_F004);
		wr(abm_pkg::OFS_CFG, 32'h0000_0002);
		wr(abm_pkg::OFS_CTRL, 32'h3BF3_0026);
		for (int i = 0; i < 6; i++) begin
			acc(abm_pkg::ACC_DATA_RD, t_addr[i], t_len[i], t_exp[i]);
		end
		wr(abm_pkg::OFS_CFG, 32'h0000_0000);
		acc(abm_pkg::ACC_DATA_WR, 32'h0000_F001, 3'h1, 4'h0);
		rdchk("status", abm_pkg::OFS_STATUS, 32'h0000_0007);
		chk("irq off", 32'h0, {31'h0, irq});
		wr(abm_pkg::OFS_IRQ_EN, 32'h0000_0004);
		#1 chk("irq on", 32'h1, {31'h0, irq});
		rdchk("irq_en", abm_pkg::OFS_IRQ_EN, 32'h0000_0004);
		wr(abm_pkg::OFS_CLEAR, 32'h0000_0004);
		rdchk("status", abm_pkg::OFS_STATUS, 32'h0000_0003);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test ranges done");
		// Task switch drops only local enables
		wr(abm_pkg::OFS_CFG, 32'h0000_0002);
		@(posedge hclk);
		task_switch <= 1'b1;
		@(posedge hclk);
		task_switch <= 1'b0;
		rdchk("ctrl", abm_pkg::OFS_CTRL, 32'h3BF3_0022);
		acc(abm_pkg::ACC_DATA_WR, 32'h0000_F005, 3'h3, 4'h4);
		$display("test task switch done");
		// Two-byte range on breakpoint 3 at F000: F000-F001 only
		wr(abm_pkg::OFS_CTRL, 32'h7000_0080);
		acc(abm_pkg::ACC_DATA_RD, 32'h0000_F001, 3'h0, 4'h8);
		acc(abm_pkg::ACC_DATA_RD, 32'h0000_F002, 3'h0, 4'h0);
		acc(abm_pkg::ACC_DATA_WR, 32'h0000_EFFF, 3'h1, 4'h8);
		$display("test two byte range done");
		// Every access type against every access kind, extensions bit off and on
		for (int d = 0; d < 2; d++) begin
			wr(abm_pkg::OFS_CFG, 32'(d));
			for (int t = 0; t < 4; t++) begin
				wr(abm_pkg::OFS_CTRL, 32'h0000_0002 | (32'(t) << abm_pkg::TYPE_POS));
				for (int k = 0; k < 5; k++) begin
					acc(abm_pkg::abm_kind_e'(k), 32'h0000_F000, 3'h0,
						{3'h0, type_hit(t[1:0], abm_pkg::abm_kind_e'(k), d[0])});
				end
			end
		end
		$display("test access types done");
		// Reset in mid-run returns control, breakpoint 0 and status to their reset values
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk("ctrl after reset", abm_pkg::OFS_CTRL, abm_pkg::CTRL_RST);
		rdchk("bp0 after reset", abm_pkg::OFS_BP_BASE, abm_pkg::BP_ADDR_RST);
		rdchk("status after reset", abm_pkg::OFS_STATUS, 32'(abm_pkg::FLAG_RST));
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule : abm_top_tb_top

/* File: common/abm_pkg.sv */
// ==========================================================
// Shared constants of the address breakpoint matcher
package abm_pkg;

	// ==========================================================
	// Register offsets (byte addresses on the AHB-Lite bus)
	localparam logic [7:0] OFS_BP_BASE = 8'h00; // Breakpoint n sits at OFS_BP_BASE + 4*n
	localparam logic [7:0] OFS_CTRL = 8'h1C;
	localparam logic [7:0] OFS_CFG = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_CLEAR = 8'h28;
	localparam logic [7:0] OFS_IRQ_EN = 8'h2C;

	// ==========================================================
	// Field positions inside the debug control register
	localparam int LOCAL_EN_POS = 0; // Local enable of breakpoint n at 2*n
	localparam int GLOBAL_EN_POS = 1; // Global enable of breakpoint n at 2*n+1
	localparam int TYPE_POS = 16; // Access type of breakpoint n at 16+4*n
	localparam int LEN_POS = 18; // Range length of breakpoint n at 18+4*n
	localparam int FIELD_STEP = 4;
	localparam int CFG_DE_POS = 0;
	localparam int CFG_LONG_POS = 1;

	// ==========================================================
	// Writable bits and values after reset
	localparam logic [31:0] CTRL_WMASK = 32'hFFFF_00FF;
	localparam logic [31:0] LOCAL_EN_MASK = 32'h0000_0055;
	localparam logic [31:0] GLOBAL_EN_MASK = 32'h0000_00AA;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] BP_ADDR_RST = 32'h0000_0000;
	localparam logic [1:0] CFG_RST = 2'h0;
	localparam logic [3:0] FLAG_RST = 4'h0;

	// ==========================================================
	// Range length encodings and the span each gives, less one byte
	localparam logic [1:0] LEN_1B = 2'h0;
	localparam logic [1:0] LEN_2B = 2'h1;
	localparam logic [1:0] LEN_8B = 2'h2;
	localparam logic [1:0] LEN_4B = 2'h3;
	localparam logic [2:0] SPAN_1B = 3'h0;
	localparam logic [2:0] SPAN_2B = 3'h1;
	localparam logic [2:0] SPAN_4B = 3'h3;
	localparam logic [2:0] SPAN_8B = 3'h7;

	// ==========================================================
	// Access type encodings
	localparam logic [1:0] TYPE_EXEC = 2'h0;
	localparam logic [1:0] TYPE_WR = 2'h1;
	localparam logic [1:0] TYPE_IO = 2'h2;
	localparam logic [1:0] TYPE_RW = 2'h3;

	// Kind of access presented by the processor pipeline
	typedef enum logic [2:0] {ACC_FETCH, ACC_DATA_RD, ACC_DATA_WR, ACC_IO_RD, ACC_IO_WR} abm_kind_e;

endpackage : abm_pkg

/* File: core/abm_range_cmp.sv */
`timescale 1ns/10ps
// ==========================================================
// One breakpoint comparator: type select, low-bit masking, byte overlap
module abm_range_cmp #(
	parameter int ADDR_W = 32
) (
	input wire logic [ADDR_W-1:0] bp_addr,
	input wire logic [1:0] range_length,
	input wire logic [1:0] access_type,
	input wire logic debug_extensions_bit,
	input wire logic long_mode,
	input wire logic armed,
	input wire logic acc_valid,
	input wire abm_pkg::abm_kind_e acc_kind,
	input wire logic [ADDR_W-1:0] acc_addr,
	input wire logic [2:0] acc_len_m1,
	output logic hit
);
	logic [2:0] span_m1;
	logic len_ok;
	logic type_ok;
	logic [ADDR_W:0] base;
	logic [ADDR_W:0] rng_last;
	logic [ADDR_W:0] acc_first;
	logic [ADDR_W:0] acc_last;

	// Span of the range; the 8-byte form only exists in long mode
	always_comb begin
		len_ok = 1'b1;
		case (range_length)
			abm_pkg::LEN_1B: span_m1 = abm_pkg::SPAN_1B;
			abm_pkg::LEN_2B: span_m1 = abm_pkg::SPAN_2B;
			abm_pkg::LEN_4B: span_m1 = abm_pkg::SPAN_4B;
			abm_pkg::LEN_8B: begin
				span_m1 = abm_pkg::SPAN_8B;
				len_ok = long_mode;
			end
			default: span_m1 = abm_pkg::SPAN_1B;
		endcase
	end

	// Which access kind arms a match
	always_comb begin
		case (access_type)
			abm_pkg::TYPE_EXEC: type_ok = (acc_kind == abm_pkg::ACC_FETCH);
			abm_pkg::TYPE_WR: type_ok = (acc_kind == abm_pkg::ACC_DATA_WR);
			abm_pkg::TYPE_RW: type_ok = (acc_kind == abm_pkg::ACC_DATA_RD) || (acc_kind == abm_pkg::ACC_DATA_WR);
			abm_pkg::TYPE_IO: type_ok = debug_extensions_bit &&
				((acc_kind == abm_pkg::ACC_IO_RD) || (acc_kind == abm_pkg::ACC_IO_WR));
			default: type_ok = 1'b0;
		endcase
	end

	// Masked base forms the range; one extra bit keeps the top from wrapping
	assign base = {1'b0, bp_addr & ~ADDR_W'(span_m1)};
	assign rng_last = base + (ADDR_W + 1)'(span_m1);
	assign acc_first = {1'b0, acc_addr};
	assign acc_last = acc_first + (ADDR_W + 1)'(acc_len_m1);

	// Any touched byte inside the range is enough
	assign hit = acc_valid && armed && type_ok && len_ok && (acc_first <= rng_last) && (base <= acc_last);

endmodule : abm_range_cmp

/* File: core/abm_top.sv */
`timescale 1ns/10ps
// What this block does
// - Four registers each hold a breakpoint virtual address compared with accesses.
// - Local enables arm for the current task; a task switch clears them all.
// - Global enables arm for all tasks; only software writes change them.
// - Access type plus debug extensions bit select the triggering access kind.
// - Range length masks low bits of the stored address to form a range.
// - Matching type and any accessed byte in range raises a debug exception.
// - Length 00=1, 01=2, 11=4, 10=8 bytes; 8 bytes only in long mode.
// - Type 00 fetch, 01 write, 11 read/write, 10 I/O only with extensions.
module abm_top #(
	parameter int ADDR_W = 32,
	parameter int NUM_BP = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic acc_valid,
	input wire abm_pkg::abm_kind_e acc_kind,
	input wire logic [ADDR_W-1:0] acc_addr,
	input wire logic [2:0] acc_len_m1,
	input wire logic task_switch,
	output logic debug_exception,
	output logic [NUM_BP-1:0] bp_hit,
	output logic irq
);
	// ==========================================================
	// State
	logic [ADDR_W-1:0] bp_addr_reg [NUM_BP];
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [1:0] cfg_reg;
	logic [NUM_BP-1:0] status_reg;
	logic [NUM_BP-1:0] status_next;
	logic [NUM_BP-1:0] irq_en_reg;
	logic [NUM_BP-1:0] bp_hit_reg;
	logic debug_exception_reg;
	logic [31:0] hrdata_reg;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic addr_take;
	logic [NUM_BP-1:0] hits;
	logic [NUM_BP-1:0] armed;
	logic [NUM_BP-1:0] clr_bits;
	logic [31:0] rd_mux;
	logic wr_ctrl;
	logic de_bit;
	logic long_mode;

	// ==========================================================
	// AHB-Lite slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign addr_take = hsel && htrans[1] && hready;
	assign wr_ctrl = wr_pend_reg && (wr_addr_reg == abm_pkg::OFS_CTRL);
	assign de_bit = cfg_reg[abm_pkg::CFG_DE_POS];
	assign long_mode = cfg_reg[abm_pkg::CFG_LONG_POS];

	// Capture a write address phase for use in the following data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= addr_take && hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	// Read multiplexer; unmapped and write-only words read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int n = 0; n < NUM_BP; n++) begin
			if (haddr[7:0] == abm_pkg::OFS_BP_BASE + 8'(4 * n)) begin
				rd_mux = 32'(bp_addr_reg[n]);
			end
		end
		case (haddr[7:0])
			abm_pkg::OFS_CTRL: rd_mux = ctrl_reg;
			abm_pkg::OFS_CFG: rd_mux = {30'h0000_0000, cfg_reg};
			abm_pkg::OFS_STATUS: rd_mux = 32'(status_reg);
			abm_pkg::OFS_IRQ_EN: rd_mux = 32'(irq_en_reg);
			default: ;
		endcase
	end

	// Read data is sampled in the address phase and stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (addr_take && !hwrite) begin
			hrdata_reg <= rd_mux;
		end
	end

	// ==========================================================
	// Breakpoint address registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int n = 0; n < NUM_BP; n++) begin
				bp_addr_reg[n] <= ADDR_W'(abm_pkg::BP_ADDR_RST);
			end
		end else if (wr_pend_reg) begin
			for (int n = 0; n < NUM_BP; n++) begin
				if (wr_addr_reg == abm_pkg::OFS_BP_BASE + 8'(4 * n)) begin
					bp_addr_reg[n] <= hwdata[ADDR_W-1:0];
				end
			end
		end
	end

	// ==========================================================
	// Debug control register: software writes, task switch drops local enables
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl) begin
			ctrl_next = hwdata & abm_pkg::CTRL_WMASK;
		end
		if (task_switch) begin
			ctrl_next = ctrl_next & ~abm_pkg::LOCAL_EN_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= abm_pkg::CTRL_RST;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Debug extensions and long mode bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg <= abm_pkg::CFG_RST;
		end else if (wr_pend_reg && wr_addr_reg == abm_pkg::OFS_CFG) begin
			cfg_reg <= hwdata[1:0];
		end
	end

	// ==========================================================
	// Comparators, one per breakpoint
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
			assign armed[gi] = ctrl_reg[abm_pkg::LOCAL_EN_POS + 2 * gi] ||
				ctrl_reg[abm_pkg::GLOBAL_EN_POS + 2 * gi];
			abm_range_cmp #(.ADDR_W(ADDR_W)) u_cmp (
				.bp_addr(bp_addr_reg[gi]),
				.range_length(ctrl_reg[abm_pkg::LEN_POS + abm_pkg::FIELD_STEP * gi +: 2]),
				.access_type(ctrl_reg[abm_pkg::TYPE_POS + abm_pkg::FIELD_STEP * gi +: 2]),
				.debug_extensions_bit(de_bit),
				.long_mode(long_mode),
				.armed(armed[gi]),
				.acc_valid(acc_valid),
				.acc_kind(acc_kind),
				.acc_addr(acc_addr),
				.acc_len_m1(acc_len_m1),
				.hit(hits[gi])
			);
		end
	endgenerate

	// Exception pulse and per-breakpoint hit, one cycle after the access
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bp_hit_reg <= NUM_BP'(abm_pkg::FLAG_RST);
			debug_exception_reg <= 1'b0;
		end else begin
			bp_hit_reg <= hits;
			debug_exception_reg <= |hits;
		end
	end

	assign bp_hit = bp_hit_reg;
	assign debug_exception = debug_exception_reg;

	// ==========================================================
	// Interrupt: sticky status, write-one-to-clear, enable mask
	assign clr_bits = (wr_pend_reg && wr_addr_reg == abm_pkg::OFS_CLEAR) ? hwdata[NUM_BP-1:0] : '0;
	assign status_next = (status_reg & ~clr_bits) | hits; // Set wins over clear

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= NUM_BP'(abm_pkg::FLAG_RST);
			irq_en_reg <= NUM_BP'(abm_pkg::FLAG_RST);
		end else begin
			status_reg <= status_next;
			if (wr_pend_reg && wr_addr_reg == abm_pkg::OFS_IRQ_EN) begin
				irq_en_reg <= hwdata[NUM_BP-1:0];
			end
		end
	end

	assign irq = |(status_reg & irq_en_reg);

	// ==========================================================
	// Checks
	property p_bp_load;
		@(posedge hclk) disable iff (!hresetn)
		(wr_pend_reg && wr_addr_reg == abm_pkg::OFS_BP_BASE) |=> (bp_addr_reg[0] == $past(hwdata[ADDR_W-1:0]));
	endproperty
	a_bp_load: assert property (p_bp_load) else $error("breakpoint address not loaded");

	property p_task_clear;
		@(posedge hclk) disable iff (!hresetn)
		task_switch |=> ((ctrl_reg & abm_pkg::LOCAL_EN_MASK) == 32'h0000_0000);
	endproperty
	a_task_clear: assert property (p_task_clear) else $error("local enable survived task switch");

	property p_global_kept;
		@(posedge hclk) disable iff (!hresetn)
		!wr_ctrl |=> ((ctrl_reg & abm_pkg::GLOBAL_EN_MASK) == ($past(ctrl_reg) & abm_pkg::GLOBAL_EN_MASK));
	endproperty
	a_global_kept: assert property (p_global_kept) else $error("global enable changed without write");

	property p_fetch_type;
		@(posedge hclk) disable iff (!hresetn)
		(acc_valid && acc_kind == abm_pkg::ACC_FETCH &&
			ctrl_reg[abm_pkg::TYPE_POS +: 2] != abm_pkg::TYPE_EXEC) |=> !bp_hit[0];
	endproperty
	a_fetch_type: assert property (p_fetch_type) else $error("fetch hit a data breakpoint");

	property p_exact_byte;
		@(posedge hclk) disable iff (!hresetn)
		(acc_valid && armed[0] && acc_kind == abm_pkg::ACC_DATA_RD && acc_len_m1 == 3'h0 &&
			ctrl_reg[abm_pkg::TYPE_POS +: 2] == abm_pkg::TYPE_RW &&
			ctrl_reg[abm_pkg::LEN_POS +: 2] == abm_pkg::LEN_4B &&
			acc_addr == (bp_addr_reg[0] | ADDR_W'(3))) |=> bp_hit[0] && debug_exception;
	endproperty
	a_exact_byte: assert property (p_exact_byte) else $error("last byte of 4-byte range missed");

	property p_exception_follows;
		@(posedge hclk) disable iff (!hresetn)
		(|hits) |=> debug_exception ##1 (debug_exception == $past(|hits));
	endproperty
	a_exception_follows: assert property (p_exception_follows) else $error("debug exception not raised");

	property p_len8_long;
		@(posedge hclk) disable iff (!hresetn)
		(ctrl_reg[abm_pkg::LEN_POS +: 2] == abm_pkg::LEN_8B && !long_mode) |=> !bp_hit[0];
	endproperty
	a_len8_long: assert property (p_len8_long) else $error("8-byte range used outside long mode");

	property p_io_needs_de;
		@(posedge hclk) disable iff (!hresetn)
		(ctrl_reg[abm_pkg::TYPE_POS +: 2] == abm_pkg::TYPE_IO && !de_bit) |=> !bp_hit[0];
	endproperty
	a_io_needs_de: assert property (p_io_needs_de) else $error("I/O breakpoint without extensions");

	property p_disarmed_quiet;
		@(posedge hclk) disable iff (!hresetn)
		(armed == '0) |=> !debug_exception && (bp_hit == '0);
	endproperty
	a_disarmed_quiet: assert property (p_disarmed_quiet) else $error("disarmed breakpoint fired");

	property p_status_sticky;
		@(posedge hclk) disable iff (!hresetn)
		(status_reg[0] && !clr_bits[0]) |=> status_reg[0] ##1 (irq || !irq_en_reg[0] || !status_reg[0]);
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

endmodule : abm_top
